// ==== core/tpw_pkg.sv ====
// shared constants and types of the pwm temperature output block
package tpw_pkg;
    // ==========================================================
    // clock and counter sizing
    localparam int CLK_MHZ = 100;
    localparam int CNT_W = 27;
    localparam int SETTLE_CYC = 3;
    // ==========================================================
    // times in their own units, and cycle counts derived from them
    localparam int TH_NOM_US = 40000;
    localparam int TH_NOM_CYC = TH_NOM_US * CLK_MHZ;
    localparam int PWRDN_US = 750000;
    localparam int PWRDN_CYC = PWRDN_US * CLK_MHZ;
    localparam int PULSE_MIN_NS = 20;
    localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int START_MAX_NS = 25000;
    localparam int START_MAX_CYC = (START_MAX_NS * CLK_MHZ) / 1000;
    localparam int START_US = 17;
    localparam int START_CYC = START_US * CLK_MHZ;
    // ==========================================================
    // rate scaling: quarter is a shift by two, double a shift by one
    localparam int QUARTER_SH = 2;
    localparam int DOUBLE_SH = 1;
    // ==========================================================
    // values after reset
    localparam logic RST_OUT_LEVEL = 1'b1;
    localparam logic RST_OUT_OE_N = 1'b0;
    // ==========================================================
    // three-level pin codes and the modes they select
    typedef enum logic [1:0] {
        TPW_LVL_LOW = 2'h0,
        TPW_LVL_FLOAT = 2'h1,
        TPW_LVL_HIGH = 2'h2
    } tpw_lvl_t;
    localparam tpw_lvl_t MODE_ONESHOT = TPW_LVL_LOW;
    localparam tpw_lvl_t MODE_CONT = TPW_LVL_FLOAT;
    localparam tpw_lvl_t MODE_CHAIN = TPW_LVL_HIGH;
    // ==========================================================
    // output sequencer states, gray along pwrup-idle-high-low-start-buffer
    typedef enum logic [2:0] {
        TPW_ST_PWRUP = 3'h0,
        TPW_ST_IDLE = 3'h1,
        TPW_ST_HIGH = 3'h3,
        TPW_ST_LOW = 3'h2,
        TPW_ST_START = 3'h6,
        TPW_ST_BUFFER = 3'h7
    } tpw_st_t;
endpackage

// ==== core/tpw_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module tpw_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } tpw_sync_t;

    tpw_sync_t r_q;
    tpw_sync_t r_d;

    // first stage feeds only the second stage
    always_comb begin
        r_d.meta = asyncIn;
        r_d.stable = r_q.meta;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign syncOut = r_q.stable;
endmodule

// ==== core/tpw_fifo.sv ====
// conversion result fifo with registered ready and valid flags
`timescale 1ns/1ps
module tpw_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic wrValid,
    input wire logic [W-1:0] wrData,
    output logic wrReady,
    output logic rdValid,
    output logic [W-1:0] rdData,
    input wire logic rdReady
);
    localparam int AW = $clog2(DEPTH);

    // ==========================================================
    // state
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic notFull;
        logic notEmpty;
    } tpw_fifo_t;

    tpw_fifo_t f_q;
    tpw_fifo_t f_d;
    logic push;
    logic pop;

    always_comb begin
        f_d = f_q;
        push = wrValid && f_q.notFull;
        pop = rdReady && f_q.notEmpty;
        if (push) begin
            f_d.mem[f_q.wp] = wrData;
            f_d.wp = (f_q.wp == AW'(DEPTH - 1)) ? '0 : f_q.wp + 1'b1;
        end
        if (pop) begin
            f_d.rp = (f_q.rp == AW'(DEPTH - 1)) ? '0 : f_q.rp + 1'b1;
        end
        f_d.cnt = f_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        // flags registered so both handshakes leave straight from flops
        f_d.notFull = (f_d.cnt != (AW + 1)'(DEPTH));
        f_d.notEmpty = (f_d.cnt != '0);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            f_q <= '0;
            f_q.notFull <= 1'b1;
        end else begin
            f_q <= f_d;
        end
    end

    assign wrReady = f_q.notFull;
    assign rdValid = f_q.notEmpty;
    assign rdData = f_q.mem[f_q.rp];
endmodule

// ==== core/tpw_core.sv ====
// pwm temperature output sequencer: continuous, one-shot and daisy-chain
`timescale 1ns/1ps
// Overview of operation
// - continuous mode emits periods back to back
// - rate input sampled once at power-up
// - one-shot request: low of at least 20 ns
// - one-shot emits exactly one period after release
// - series resistor switched in only in one-shot
// - rate level picks quarter, nominal or double high
// - latched rate applies to continuous and one-shot
// - chain mode: rate pin is chain input, nominal
// - after own period emit 17 us start pulse
// - after start pulse forward chain input unchanged
// - detect start pulse, append own period, pulse
// - input held high powers down, needs start
// - mode input sampled at power-up, three modes
// - high period fixed, low period carries temperature
module tpw_core
    import tpw_pkg::*;
#(
    parameter int DATA_W = 24,
    parameter int FIFO_DEPTH = 8,
    parameter int TH_NOM = TH_NOM_CYC,
    parameter int PWRDN = PWRDN_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic modeSelectInput,
    input wire logic modeSelectFloat,
    input wire logic rateSelectChainInput,
    input wire logic rateSelectChainFloat,
    input wire logic outPinIn,
    output logic outPinOut,
    output logic outPinOeN,
    output logic seriesResOn,
    output logic lowPower,
    input wire logic convValid,
    input wire logic [DATA_W-1:0] convData,
    output logic convReady
);
    // ==========================================================
    // pin synchronisers
    logic [3:0] pinSync;
    logic modeS;
    logic modeFloatS;
    logic chainS;
    logic rateFloatS;
    logic outS;

    tpw_sync #(
        .W(4)
    ) u_pin_sync (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn({modeSelectInput, modeSelectFloat, rateSelectChainInput, rateSelectChainFloat}),
        .syncOut(pinSync)
    );

    tpw_sync #(
        .W(1)
    ) u_out_sync (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn(outPinIn),
        .syncOut(outS)
    );

    assign modeS = pinSync[3];
    assign modeFloatS = pinSync[2];
    assign chainS = pinSync[1];
    assign rateFloatS = pinSync[0];

    // ==========================================================
    // result fifo between modulator and sequencer
    logic rdValid;
    logic [DATA_W-1:0] rdData;
    logic take;

    tpw_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .wrValid(convValid),
        .wrData(convData),
        .wrReady(convReady),
        .rdValid(rdValid),
        .rdData(rdData),
        .rdReady(take)
    );

    // ==========================================================
    // state
    typedef struct packed {
        tpw_st_t st;
        tpw_lvl_t mode;
        tpw_lvl_t rate;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] run;
        logic prevLvl;
        logic armed;
        logic [DATA_W-1:0] word;
        logic sleep;
        logic outData;
        logic outOeN;
        logic seriesRes;
    } tpw_core_t;

    tpw_core_t q;
    tpw_core_t d;

    function automatic tpw_lvl_t lvlOf(input logic lvl, input logic flt);
        tpw_lvl_t res;
        if (flt) begin
            res = TPW_LVL_FLOAT;
        end else if (lvl) begin
            res = TPW_LVL_HIGH;
        end else begin
            res = TPW_LVL_LOW;
        end
        return res;
    endfunction

    // ==========================================================
    // period targets
    logic lineS;
    logic [CNT_W-1:0] thTarget;
    logic [CNT_W-1:0] tlTarget;
    logic [CNT_W-1:0] tlRaw;
    tpw_lvl_t modeNow;

    assign lineS = (q.mode == MODE_CHAIN) ? chainS : outS;
    assign modeNow = lvlOf(modeS, modeFloatS);

    always_comb begin
        thTarget = CNT_W'(TH_NOM);
        tlRaw = CNT_W'(q.word);
        tlTarget = tlRaw;
        if (q.mode != MODE_CHAIN) begin
            unique case (q.rate)
                TPW_LVL_LOW: begin
                    thTarget = CNT_W'(TH_NOM) >> QUARTER_SH;
                    tlTarget = tlRaw >> QUARTER_SH;
                end
                TPW_LVL_HIGH: begin
                    thTarget = CNT_W'(TH_NOM) << DOUBLE_SH;
                    tlTarget = tlRaw >> QUARTER_SH;
                end
                default: begin
                    thTarget = CNT_W'(TH_NOM);
                    tlTarget = tlRaw;
                end
            endcase
        end
        // a zero low target would hold the low phase for the whole counter range
        if (tlTarget == '0) begin
            tlTarget = CNT_W'(1);
        end
    end

    // ==========================================================
    // sequencer
    always_comb begin
        d = q;
        take = 1'b0;
        d.cnt = q.cnt + 1'b1;
        // length of the current level on the sensed line
        if (lineS == q.prevLvl) begin
            if (q.run != '1) begin
                d.run = q.run + 1'b1;
            end
        end else begin
            d.run = CNT_W'(1);
        end
        d.prevLvl = lineS;
        unique case (q.st)
            TPW_ST_PWRUP: begin
                if (q.cnt == CNT_W'(SETTLE_CYC)) begin
                    d.mode = modeNow;
                    d.rate = lvlOf(chainS, rateFloatS);
                    d.seriesRes = (modeNow == MODE_ONESHOT);
                    d.cnt = '0;
                    d.armed = 1'b0;
                    if (modeNow == MODE_CONT) begin
                        d.st = TPW_ST_HIGH;
                        take = 1'b1;
                    end else begin
                        d.st = TPW_ST_IDLE;
                    end
                end
            end
            TPW_ST_IDLE: begin
                // our own low edge must not read back as a request
                d.armed = q.armed | lineS;
                if (q.mode == MODE_ONESHOT) begin
                    if (q.armed && lineS && !q.prevLvl && q.run >= CNT_W'(PULSE_MIN_CYC)) begin
                        d.st = TPW_ST_HIGH;
                        d.cnt = '0;
                        take = 1'b1;
                    end
                end else if (q.armed && !lineS && q.prevLvl && q.run >= CNT_W'(PULSE_MIN_CYC)
                             && q.run <= CNT_W'(START_MAX_CYC)) begin
                    d.st = TPW_ST_HIGH;
                    d.cnt = '0;
                    d.sleep = 1'b0;
                    take = 1'b1;
                end else if (lineS && q.prevLvl && q.run == CNT_W'(PWRDN)) begin
                    d.sleep = 1'b1;
                end
            end
            TPW_ST_HIGH: begin
                if (q.cnt == thTarget - 1'b1) begin
                    d.st = TPW_ST_LOW;
                    d.cnt = '0;
                end
            end
            TPW_ST_LOW: begin
                if (q.cnt == tlTarget - 1'b1) begin
                    d.cnt = '0;
                    d.armed = 1'b0;
                    unique case (q.mode)
                        MODE_CONT: begin
                            d.st = TPW_ST_HIGH;
                            take = 1'b1;
                        end
                        MODE_ONESHOT: begin
                            d.st = TPW_ST_IDLE;
                        end
                        default: begin
                            d.st = TPW_ST_START;
                        end
                    endcase
                end
            end
            TPW_ST_START: begin
                if (q.cnt == CNT_W'(START_CYC - 1)) begin
                    d.st = TPW_ST_BUFFER;
                    d.cnt = '0;
                end
            end
            TPW_ST_BUFFER: begin
                // a spent part waits for power-down before it re-arms
                if (lineS && q.prevLvl && q.run == CNT_W'(PWRDN)) begin
                    d.st = TPW_ST_IDLE;
                    d.sleep = 1'b1;
                    d.armed = 1'b1;
                end
            end
            default: begin
                d.st = TPW_ST_PWRUP;
                d.cnt = '0;
            end
        endcase
        // stale words are reused when the modulator lags
        if (take && rdValid) begin
            d.word = rdData;
        end
        // pin level follows the next state so it lines up with it
        if (d.st == TPW_ST_LOW) begin
            d.outData = 1'b0;
        end else if ((d.st == TPW_ST_IDLE || d.st == TPW_ST_BUFFER) && d.mode == MODE_CHAIN) begin
            d.outData = chainS;
        end else begin
            d.outData = 1'b1;
        end
        d.outOeN = RST_OUT_OE_N;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.st <= TPW_ST_PWRUP;
            q.mode <= MODE_CONT;
            q.rate <= TPW_LVL_FLOAT;
            q.prevLvl <= 1'b1;
            q.outData <= RST_OUT_LEVEL;
            q.outOeN <= RST_OUT_OE_N;
        end else begin
            q <= d;
        end
    end

    assign outPinOut = q.outData;
    assign outPinOeN = q.outOeN;
    assign seriesResOn = q.seriesRes;
    assign lowPower = q.sleep;

    // ==========================================================
    // assertions
    a_cont_unbroken: assert property (@(posedge mclk) disable iff (!resetn)
        (q.mode == MODE_CONT && q.st != TPW_ST_PWRUP) |-> (q.st == TPW_ST_HIGH || q.st == TPW_ST_LOW))
        else $error("continuous mode left the period train");

    a_rate_held: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st != TPW_ST_PWRUP) |=> $stable(q.rate))
        else $error("rate code changed after power-up");

    a_mode_held: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st != TPW_ST_PWRUP) |=> ($stable(q.mode) && q.st != TPW_ST_PWRUP))
        else $error("mode code changed after power-up");

    a_req_filter: assert property (@(posedge mclk) disable iff (!resetn)
        (q.mode == MODE_ONESHOT && q.st == TPW_ST_IDLE && d.st == TPW_ST_HIGH)
        |-> ($past(outS) == 1'b0 && q.run >= CNT_W'(PULSE_MIN_CYC)))
        else $error("one-shot started without a long enough low");

    a_oneshot_once: assert property (@(posedge mclk) disable iff (!resetn)
        (q.mode == MODE_ONESHOT && q.st == TPW_ST_LOW && d.st != TPW_ST_LOW)
        |=> (q.st == TPW_ST_IDLE && outPinOut) [*2])
        else $error("one-shot emitted more than one period");

    a_series_res: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st != TPW_ST_PWRUP) |-> (seriesResOn == (q.mode == MODE_ONESHOT)))
        else $error("series resistor state wrong for mode");

    a_high_fixed: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st == TPW_ST_HIGH && d.st == TPW_ST_LOW)
        |-> (q.cnt == ((q.mode == MODE_CHAIN || q.rate == TPW_LVL_FLOAT) ? CNT_W'(TH_NOM - 1) :
             (q.rate == TPW_LVL_LOW) ? CNT_W'(TH_NOM / 4 - 1) : CNT_W'(TH_NOM * 2 - 1))))
        else $error("high period length wrong for rate");

    a_start_width: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st == TPW_ST_START && d.st != TPW_ST_START) |-> (q.cnt == CNT_W'(START_CYC - 1) && outPinOut))
        else $error("chain start pulse width wrong");

    a_chain_pass: assert property (@(posedge mclk) disable iff (!resetn)
        (q.mode == MODE_CHAIN && q.st == TPW_ST_BUFFER && d.st == TPW_ST_BUFFER) |=> (outPinOut == $past(chainS)))
        else $error("chain input not forwarded");

    a_chain_detect: assert property (@(posedge mclk) disable iff (!resetn)
        (q.mode == MODE_CHAIN && q.st == TPW_ST_IDLE && d.st == TPW_ST_HIGH)
        |-> (q.run <= CNT_W'(START_MAX_CYC) && q.run >= CNT_W'(PULSE_MIN_CYC) && !chainS))
        else $error("conversion started without a valid start pulse");

    a_power_down: assert property (@(posedge mclk) disable iff (!resetn)
        (q.mode == MODE_CHAIN && q.st != TPW_ST_HIGH && q.st != TPW_ST_LOW && q.st != TPW_ST_START
         && q.prevLvl && chainS && q.run == CNT_W'(PWRDN)) |=> lowPower)
        else $error("held-high chain input did not power down");
endmodule

// ==== dv/tpw_host_model.sv ====
// host timer model: measures output runs and issues one-shot requests
`timescale 1ns/1ps
module tpw_host_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic wireLvl,
    input wire logic reqStart,
    input wire logic [7:0] reqCycles,
    output logic hostLow,
    output logic repValid,
    output int repHigh,
    output int repLow
);
    // ==========================================================
    // run counters; lows caused by our own request are not measured
    int hiCnt, loCnt, lastHigh;
    logic [7:0] reqCnt;
    logic prevLvl, hadFall;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {hiCnt, loCnt, lastHigh, repHigh, repLow} <= '0;
            {reqCnt, hostLow, repValid, hadFall} <= '0;
            prevLvl <= 1'b1;
        end else begin
            repValid <= 1'b0;
            prevLvl <= wireLvl;
            if (reqStart) begin
                hostLow <= 1'b1;
                reqCnt <= reqCycles;
                hadFall <= 1'b0;
            end else if (hostLow) begin
                if (reqCnt <= 8'h01) hostLow <= 1'b0;
                reqCnt <= reqCnt - 8'h01;
            end
            if (wireLvl) hiCnt <= prevLvl ? hiCnt + 1 : 1;
            else loCnt <= prevLvl ? 1 : loCnt + 1;
            if (!wireLvl && prevLvl && !hostLow) begin
                hadFall <= 1'b1;
                lastHigh <= hiCnt;
            end
            if (wireLvl && !prevLvl && hadFall && !hostLow) begin
                repValid <= 1'b1;
                repHigh <= lastHigh;
                repLow <= loCnt;
            end
        end
    end
endmodule

// ==== dv/tb.sv ====
// self-checking bench of the pwm temperature output sequencer
`timescale 1ns/1ps
module tb;
    import tpw_pkg::*;
    // ==========================================================
    // short counts keep the run brief
    localparam int THN = 40;
    localparam int PWD = 4000;
    logic mclk, resetn, modeSelectInput, modeSelectFloat, rateSelectChainInput, rateSelectChainFloat;
    logic outPinOut, outPinOeN, seriesResOn, lowPower, convValid, convReady;
    logic hostLow, wireLvl, reqStart, repValid;
    logic [23:0] convData, w;
    logic [7:0] reqCycles;
    int repHigh, repLow, errors, n_checks, skip, eh, el, lows;
    real lastTemp;
    tpw_lvl_t rNow;
    int expHigh[$], expLow[$];
    tpw_lvl_t rates[3] = '{TPW_LVL_LOW, TPW_LVL_FLOAT, TPW_LVL_HIGH};
    // host low beats the device whatever the series resistor state
    assign wireLvl = hostLow ? 1'b0 : (outPinOeN ? 1'b1 : outPinOut);
    tpw_core #(.TH_NOM(THN), .PWRDN(PWD)) DUT (.mclk(mclk), .resetn(resetn),
        .modeSelectInput(modeSelectInput), .modeSelectFloat(modeSelectFloat),
        .rateSelectChainInput(rateSelectChainInput), .rateSelectChainFloat(rateSelectChainFloat),
        .outPinIn(wireLvl), .outPinOut(outPinOut), .outPinOeN(outPinOeN), .seriesResOn(seriesResOn),
        .lowPower(lowPower), .convValid(convValid), .convData(convData), .convReady(convReady));
    tpw_host_model host (.mclk(mclk), .resetn(resetn), .wireLvl(wireLvl), .reqStart(reqStart),
        .reqCycles(reqCycles), .hostLow(hostLow), .repValid(repValid), .repHigh(repHigh), .repLow(repLow));
    // ==========================================================
    // shared tasks
    task automatic stop_test();
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic bail(input string msg);
        check(1'b0, msg);
        stop_test();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic do_reset(input tpw_lvl_t m, input tpw_lvl_t r);
        resetn <= 1'b0;
        rNow = r;
        modeSelectInput <= (m == TPW_LVL_HIGH);
        modeSelectFloat <= (m == TPW_LVL_FLOAT);
        rateSelectChainInput <= (r == TPW_LVL_HIGH);
        rateSelectChainFloat <= (r == TPW_LVL_FLOAT);
        cyc(16);
        resetn <= 1'b1;
    endtask
    task automatic push(input logic [23:0] d);
        int n;
        n = 0;
        convValid <= 1'b1;
        convData <= d;
        @(posedge mclk);
        while (convReady !== 1'b1) begin
            n++;
            if (n > 5000) bail("word not taken");
            @(posedge mclk);
        end
    endtask
    task automatic wait_out(input logic lvl);
        int n;
        n = 0;
        while (outPinOut !== lvl) begin
            n++;
            if (n > 20000) bail("output level never reached");
            @(posedge mclk);
        end
    endtask
    // tail: cycles watched for stray periods once all expected ones came
    task automatic drain(input int tail);
        int n;
        n = 0;
        while (expLow.size() != 0) begin
            n++;
            if (n > 30000) bail("expected period missing");
            @(posedge mclk);
        end
        cyc(tail);
        skip = 1 << 30;
    endtask
    task automatic expect_period(input int th, input int tl);
        expHigh.push_back(th);
        expLow.push_back(tl);
    endtask
    task automatic request(input logic [7:0] n);
        reqCycles <= n;
        reqStart <= 1'b1;
        @(posedge mclk);
        reqStart <= 1'b0;
    endtask
    task automatic drv(input logic lvl, input int n);
        rateSelectChainInput <= lvl;
        cyc(n);
    endtask
    function automatic int exp_th(input tpw_lvl_t r);
        if (r == TPW_LVL_LOW) return THN >> QUARTER_SH;
        if (r == TPW_LVL_HIGH) return THN << DOUBLE_SH;
        return THN;
    endfunction
    function automatic int exp_tl(input tpw_lvl_t r, input logic [23:0] d);
        return (r == TPW_LVL_FLOAT) ? int'(d) : int'(d >> QUARTER_SH);
    endfunction
    // host side decode; the high rate uses the eighth-size coefficient
    function automatic real host_temp(input tpw_lvl_t r, input int th, input int tl);
        return 421.0 - ((r == TPW_LVL_HIGH) ? 93.875 : 751.0) * th / tl;
    endfunction
    // ==========================================================
    // watcher: -1 in a note means that length is not judged
    always @(posedge mclk) begin
        if (repValid === 1'b1) begin
            if (skip > 0) skip--;
            else if (expLow.size() == 0) check(1'b0, "unexpected period");
            else begin
                eh = expHigh.pop_front();
                el = expLow.pop_front();
                check((eh < 0 || repHigh == eh) && (el < 0 || repLow == el), "period lengths differ");
                lastTemp = host_temp(rNow, repHigh, repLow);
            end
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ==========================================================
    // main sequence
    initial begin
        {resetn, modeSelectInput, modeSelectFloat, rateSelectChainInput, rateSelectChainFloat} = '0;
        {convValid, convData, reqStart, reqCycles} = '0;
        {errors, n_checks, skip} = '0;
        void'($urandom(7364));
        foreach (rates[k]) begin
            do_reset(MODE_CONT, rates[k]);
            skip = 2;
            wait_out(1'b0);
            wait_out(1'b1);
            check(seriesResOn === 1'b0 && lowPower === 1'b0 && outPinOeN === 1'b0, "output stage in continuous mode");
            rateSelectChainInput <= 1'($urandom);
            rateSelectChainFloat <= 1'($urandom);
            for (int i = 0; i < 8; i++) begin
                // multiples of four keep the quartered low exact for the decode check
                w = 24'(8 + 4 * ($urandom % 14));
                push(w);
                expect_period(exp_th(rates[k]), exp_tl(rates[k], w));
            end
            expect_period(exp_th(rates[k]), exp_tl(rates[k], w));
            if (rates[k] != TPW_LVL_LOW) begin
                convData <= 24'h00ffff;
                cyc(2);
                check(convReady === 1'b0, "full buffer still ready");
            end
            convValid <= 1'b0;
            drain(0);
            lastTemp = lastTemp - host_temp(TPW_LVL_FLOAT, THN, int'(w));
            check(lastTemp < 0.01 && lastTemp > -0.01, "decoded temperature differs");
        end
        for (int k = 1; k < 3; k++) begin
            do_reset(MODE_ONESHOT, rates[k]);
            skip = 0;
            cyc(8);
            check(seriesResOn === 1'b1, "no series resistor in one-shot mode");
            w = 24'(8 + $urandom % 56);
            push(w);
            convValid <= 1'b0;
            request(8'h01);
            lows = 0;
            repeat (150) begin
                @(posedge mclk);
                if (outPinOut !== 1'b1) lows++;
            end
            check(lows == 0, "short low started a period");
            expect_period(-1, exp_tl(rates[k], w));
            request(8'h04);
            drain(300);
        end
        do_reset(MODE_CHAIN, TPW_LVL_HIGH);
        skip = 0;
        // the power-up high must outgrow the start window or its fall reads as a start
        cyc(2600);
        w = 24'(8 + $urandom % 56);
        push(w);
        push(24'(w + 24'h000005));
        convValid <= 1'b0;
        expect_period(-1, 50);
        expect_period(2800, 60);
        expect_period(-1, int'(w));
        expect_period(START_CYC, -1);
        drv(1'b0, 50);
        drv(1'b1, 2800);
        drv(1'b0, 60);
        drv(1'b1, 100);
        drv(1'b0, THN + int'(w) + START_CYC + 200);
        drv(1'b1, PWD - 100);
        check(lowPower === 1'b0, "powered down early");
        cyc(200);
        check(lowPower === 1'b1, "no power down after long high");
        expect_period(-1, 50);
        expect_period(-1, int'(w) + 5);
        expect_period(START_CYC, -1);
        drv(1'b0, 50);
        drv(1'b1, 2);
        drv(1'b0, THN + int'(w) + START_CYC + 200);
        rateSelectChainInput <= 1'b1;
        drain(100);
        stop_test();
    end
endmodule
